// [core/frr_pkg.sv]
package frr_pkg;

    // register byte offsets (one aligned word each)
    localparam logic [7:0] OFS_NV_CFG    = 8'h00;
    localparam logic [7:0] OFS_NV_DLP    = 8'h04;
    localparam logic [7:0] OFS_NV_BOOT   = 8'h08;
    localparam logic [7:0] OFS_NV_PWD    = 8'h0c;
    localparam logic [7:0] OFS_PROT_OPT  = 8'h10;
    localparam logic [7:0] OFS_VCFG      = 8'h14;
    localparam logic [7:0] OFS_VPROT     = 8'h18;
    localparam logic [7:0] OFS_VPWD      = 8'h1c;
    localparam logic [7:0] OFS_VDLP      = 8'h20;
    localparam logic [7:0] OFS_VBOOT     = 8'h24;
    localparam logic [7:0] OFS_ECC_STAT  = 8'h28;
    localparam logic [7:0] OFS_ECC_CNT   = 8'h2c;
    localparam logic [7:0] OFS_ADDR_TRAP = 8'h30;
    localparam logic [7:0] OFS_DICHK     = 8'h34;
    localparam logic [7:0] OFS_STATUS    = 8'h38;

    // protection option field positions
    localparam int OPT_PWD_SEL  = 0;
    localparam int OPT_PERS_LO  = 1;
    localparam int OPT_PERS_HI  = 2;
    localparam int OPT_DYB_INIT = 4;

    // volatile protection field positions
    localparam int VPROT_PPB = 0;
    localparam int VPROT_DYB = 1;

    // status field positions
    localparam int ST_ARMED   = 0;
    localparam int ST_KIND_LO = 1;
    localparam int ST_KIND_HI = 2;

    // reset values of nonvolatile copies and cleared registers
    localparam logic [31:0] RST_NV_CFG   = 32'h0000_0000;
    localparam logic [7:0]  RST_NV_DLP   = 8'h00;
    localparam logic [31:0] RST_NV_BOOT  = 32'h0000_0000;
    localparam logic [31:0] RST_NV_PWD   = 32'hffff_ffff;
    localparam logic [7:0]  RST_PROT_OPT = 8'h00;
    localparam logic [31:0] CLR_WORD     = 32'h0000_0000;
    localparam logic [31:0] PWD_HIDDEN   = 32'hffff_ffff;

    // command codes of the software reset pair
    localparam logic [7:0] CMD_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] CMD_RESET_EXECUTE = 8'h99;

    // signalling reset: pulse count value at the last of the four chip-select pulses
    localparam logic [1:0] SIG_LAST_PULSE = 2'h3;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {KIND_NONE, KIND_POR, KIND_HW, KIND_SW} frr_kind_e;

endpackage

// [core/frr_sig_detect.sv]
`timescale 1ns/1ps
// spots the four chip-select pulse signalling reset with alternating dq0
module frr_sig_detect (
    input  wire logic I_CLOCK,
    input  wire logic I_RST_B,
    input  wire logic i_cs_b,
    input  wire logic i_dq0,
    output logic      o_fire
);
    import frr_pkg::*;

    logic       cs_prev_ff;
    logic       dq_seen_ff;
    logic [1:0] cnt_ff;
    logic       fire_ff;
    logic       cs_rise;
    logic       dq_ok;
    logic [1:0] nxt_cnt;
    logic       nxt_fire;

    // dq0 must be low on pulses 1 and 3, high on 2 and 4
    assign cs_rise  = i_cs_b & ~cs_prev_ff;
    assign dq_ok    = (dq_seen_ff == cnt_ff[0]);
    assign nxt_fire = cs_rise & dq_ok & (cnt_ff == SIG_LAST_PULSE);
    // a wrong level restarts; a low level counts as a fresh first pulse
    assign nxt_cnt  = !cs_rise ? cnt_ff :
                      dq_ok    ? cnt_ff + 2'h1 :
                      (dq_seen_ff ? 2'h0 : 2'h1);

    // dq0 is latched while select is low so the rising edge sees it
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            cs_prev_ff <= 1'b1;
            dq_seen_ff <= 1'b0;
            cnt_ff     <= 2'h0;
            fire_ff    <= 1'b0;
        end
        else
        begin
            cs_prev_ff <= i_cs_b;
            dq_seen_ff <= i_cs_b ? dq_seen_ff : i_dq0;
            cnt_ff     <= nxt_cnt;
            fire_ff    <= nxt_fire;
        end
    end

    assign o_fire = fire_ff;
endmodule

// [core/frr_reload.sv]
`timescale 1ns/1ps
// reset-time reload of volatile registers, reached over ahb-lite
module frr_reload (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_B,
    // reset indications
    input  wire logic        I_POR,
    input  wire logic        I_HW_RST,
    input  wire logic        I_CS_B,
    input  wire logic        I_DQ0,
    input  wire logic        I_CMD_VALID,
    input  wire logic [7:0]  I_CMD,
    // ahb-lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // block state
    output logic      [31:0] O_CFG,
    output logic             O_PPB_LOCK,
    output logic             O_DYB_ACCESS,
    output logic             O_RESET_PULSE,
    output frr_pkg::frr_kind_e O_RESET_KIND
);
    import frr_pkg::*;

    // nonvolatile copies, writable by software
    logic [31:0] nv_cfg_ff;
    logic [7:0]  nv_dlp_ff;
    logic [31:0] nv_boot_ff;
    logic [31:0] nv_pwd_ff;
    logic [7:0]  prot_opt_ff;
    // volatile registers under reset policy
    logic [31:0] vcfg_ff;
    logic        ppb_lock_ff;
    logic        dyb_acc_ff;
    logic [31:0] vpwd_ff;
    logic [7:0]  vdlp_ff;
    logic [31:0] vboot_ff;
    logic [7:0]  ecc_stat_ff;
    logic [15:0] ecc_cnt_ff;
    logic [31:0] addr_trap_ff;
    logic [31:0] dichk_ff;
    // reset sequencing state
    logic        por_pend_ff;
    logic        armed_ff;
    logic        pulse_ff;
    frr_kind_e   kind_ff;
    // bus state
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [7:0]  addr_ff;
    logic [31:0] hrdata_ff;
    logic        hready_ff;

    logic        sig_fire;
    logic        por_evt;
    logic        hw_evt;
    logic        sw_evt;
    logic        full_evt;
    logic        any_evt;
    frr_kind_e   nxt_kind;
    logic        nxt_armed;
    logic        bus_take;
    logic        take_wr;
    logic        take_rd;
    logic        ppb_init;
    logic        dyb_init;
    logic [31:0] pwd_init;
    logic [31:0] wdata;

    // write strobe for one register offset in the write data phase
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_pend_ff && (addr_ff == ofs);
    endfunction

    // read value of one register offset; unmapped reads return zero
    function automatic logic [31:0] rd_mux(input logic [7:0] ofs);
        logic [31:0] v;
        v = CLR_WORD;
        unique case (ofs)
            OFS_NV_CFG:    v = nv_cfg_ff;
            OFS_NV_DLP:    v = {24'h000000, nv_dlp_ff};
            OFS_NV_BOOT:   v = nv_boot_ff;
            OFS_NV_PWD:    v = nv_pwd_ff;
            OFS_PROT_OPT:  v = {24'h000000, prot_opt_ff};
            OFS_VCFG:      v = vcfg_ff;
            OFS_VPROT:     v = {30'h00000000, dyb_acc_ff, ppb_lock_ff};
            OFS_VPWD:      v = vpwd_ff;
            OFS_VDLP:      v = {24'h000000, vdlp_ff};
            OFS_VBOOT:     v = vboot_ff;
            OFS_ECC_STAT:  v = {24'h000000, ecc_stat_ff};
            OFS_ECC_CNT:   v = {16'h0000, ecc_cnt_ff};
            OFS_ADDR_TRAP: v = addr_trap_ff;
            OFS_DICHK:     v = dichk_ff;
            OFS_STATUS:    v = {29'h00000000, kind_ff, armed_ff};
            default:       v = CLR_WORD;
        endcase
        return v;
    endfunction

    // signalling sequence on the serial pins
    frr_sig_detect u_sig (
        .I_CLOCK (I_CLOCK),
        .I_RST_B (I_RST_B),
        .i_cs_b  (I_CS_B),
        .i_dq0   (I_DQ0),
        .o_fire  (sig_fire)
    );

    // three separate indications, power-on first, software last
    assign por_evt  = I_POR | por_pend_ff;
    assign hw_evt   = I_HW_RST | sig_fire;
    assign sw_evt   = I_CMD_VALID & (I_CMD == CMD_RESET_EXECUTE) & armed_ff;
    assign full_evt = por_evt | hw_evt;
    assign any_evt  = full_evt | sw_evt;
    assign nxt_kind = por_evt ? KIND_POR :
                      hw_evt  ? KIND_HW  :
                      sw_evt  ? KIND_SW  : kind_ff;

    // the enable only survives until the next command of any kind or a power-on, pin or signalling reset
    assign nxt_armed = full_evt    ? 1'b0 :
                       I_CMD_VALID ? (I_CMD == CMD_RESET_ENABLE) : armed_ff;

    // protection defaults derived from the option bits
    assign ppb_init = (prot_opt_ff[OPT_PERS_HI:OPT_PERS_LO] != 2'h1);
    assign dyb_init = prot_opt_ff[OPT_DYB_INIT];
    // password is readable only in persistent mode with the select bit set
    assign pwd_init = (prot_opt_ff[OPT_PERS_HI] & prot_opt_ff[OPT_PWD_SEL]) ?
                      nv_pwd_ff : PWD_HIDDEN;

    // bus address phase: only whole-word single transfers are decoded
    assign bus_take = I_HSEL & I_HREADY & (I_HTRANS == HTRANS_NONSEQ) &
                      (I_HSIZE == HSIZE_WORD);
    assign take_wr  = bus_take & I_HWRITE;
    assign take_rd  = bus_take & ~I_HWRITE;
    assign wdata    = I_HWDATA;

    // reset sequencing flops
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            por_pend_ff <= 1'b1;    // first cycle after release is power-on
            armed_ff    <= 1'b0;
            pulse_ff    <= 1'b0;
            kind_ff     <= KIND_NONE;
        end
        else
        begin
            por_pend_ff <= 1'b0;
            armed_ff    <= nxt_armed;
            pulse_ff    <= any_evt;
            kind_ff     <= nxt_kind;
        end
    end

    // ahb slave: writes end with no wait, reads take one wait state
    // the wait keeps read data from a flop and sees a preceding write
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
            hrdata_ff  <= CLR_WORD;
            hready_ff  <= 1'b1;
        end
        else
        begin
            wr_pend_ff <= take_wr;
            rd_pend_ff <= take_rd;
            addr_ff    <= bus_take ? I_HADDR[7:0] : addr_ff;
            hrdata_ff  <= rd_pend_ff ? rd_mux(addr_ff) : hrdata_ff;
            hready_ff  <= ~take_rd;
        end
    end

    // nonvolatile copies: software owned, untouched by any reset event
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            nv_cfg_ff   <= RST_NV_CFG;
            nv_dlp_ff   <= RST_NV_DLP;
            nv_boot_ff  <= RST_NV_BOOT;
            nv_pwd_ff   <= RST_NV_PWD;
            prot_opt_ff <= RST_PROT_OPT;
        end
        else
        begin
            nv_cfg_ff   <= wr_hit(OFS_NV_CFG)   ? wdata       : nv_cfg_ff;
            nv_dlp_ff   <= wr_hit(OFS_NV_DLP)   ? wdata[7:0]  : nv_dlp_ff;
            nv_boot_ff  <= wr_hit(OFS_NV_BOOT)  ? wdata       : nv_boot_ff;
            nv_pwd_ff   <= wr_hit(OFS_NV_PWD)   ? wdata       : nv_pwd_ff;
            prot_opt_ff <= wr_hit(OFS_PROT_OPT) ? wdata[7:0]  : prot_opt_ff;
        end
    end

    // configuration: reloaded on every reset, read-only to software
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            vcfg_ff <= RST_NV_CFG;
        else
            vcfg_ff <= any_evt ? nv_cfg_ff : vcfg_ff;
    end

    // protection: set from option bits on full resets only
    // a software reset falls through to the bus path and keeps the value
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ppb_lock_ff <= 1'b0;
            dyb_acc_ff  <= 1'b0;
            vpwd_ff     <= PWD_HIDDEN;
        end
        else if (full_evt)
        begin
            ppb_lock_ff <= ppb_init;
            dyb_acc_ff  <= dyb_init;
            vpwd_ff     <= pwd_init;
        end
        else
        begin
            ppb_lock_ff <= wr_hit(OFS_VPROT) ? wdata[VPROT_PPB] : ppb_lock_ff;
            dyb_acc_ff  <= wr_hit(OFS_VPROT) ? wdata[VPROT_DYB] : dyb_acc_ff;
            vpwd_ff     <= vpwd_ff;
        end
    end

    // learning pattern and boot word: reload on full resets only
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            vdlp_ff  <= RST_NV_DLP;
            vboot_ff <= RST_NV_BOOT;
        end
        else if (full_evt)
        begin
            vdlp_ff  <= nv_dlp_ff;
            vboot_ff <= nv_boot_ff;
        end
        else
        begin
            vdlp_ff  <= wr_hit(OFS_VDLP)  ? wdata[7:0] : vdlp_ff;
            vboot_ff <= wr_hit(OFS_VBOOT) ? wdata      : vboot_ff;
        end
    end

    // error tracking and integrity check: cleared by every reset kind
    // a bus write in the same cycle as a reset is lost on purpose
    always_ff @(posedge I_CLOCK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ecc_stat_ff  <= 8'h00;
            ecc_cnt_ff   <= 16'h0000;
            addr_trap_ff <= CLR_WORD;
            dichk_ff     <= CLR_WORD;
        end
        else if (any_evt)
        begin
            ecc_stat_ff  <= 8'h00;
            ecc_cnt_ff   <= 16'h0000;
            addr_trap_ff <= CLR_WORD;
            dichk_ff     <= CLR_WORD;
        end
        else
        begin
            ecc_stat_ff  <= wr_hit(OFS_ECC_STAT)  ? wdata[7:0]  : ecc_stat_ff;
            ecc_cnt_ff   <= wr_hit(OFS_ECC_CNT)   ? wdata[15:0] : ecc_cnt_ff;
            addr_trap_ff <= wr_hit(OFS_ADDR_TRAP) ? wdata       : addr_trap_ff;
            dichk_ff     <= wr_hit(OFS_DICHK)     ? wdata       : dichk_ff;
        end
    end

    // outputs straight from flops; the response is always okay
    assign O_HRDATA      = hrdata_ff;
    assign O_HREADYOUT   = hready_ff;
    assign O_HRESP       = 1'b0;
    assign O_CFG         = vcfg_ff;
    assign O_PPB_LOCK    = ppb_lock_ff;
    assign O_DYB_ACCESS  = dyb_acc_ff;
    assign O_RESET_PULSE = pulse_ff;
    assign O_RESET_KIND  = kind_ff;
endmodule

// [verif/frr_reload_props.sv]
`timescale 1ns/1ps
// port checks on the reload block
module frr_reload_props (
    input wire logic               I_CLOCK,
    input wire logic               I_RST_B,
    input wire logic               I_POR,
    input wire logic               I_HW_RST,
    input wire logic               I_CMD_VALID,
    input wire logic [7:0]         I_CMD,
    input wire logic               I_HSEL,
    input wire logic [1:0]         I_HTRANS,
    input wire logic               I_HWRITE,
    input wire logic [2:0]         I_HSIZE,
    input wire logic               I_HREADY,
    input wire logic               O_HREADYOUT,
    input wire logic               O_HRESP,
    input wire logic               O_PPB_LOCK,
    input wire logic               O_DYB_ACCESS,
    input wire logic               O_RESET_PULSE,
    input wire frr_pkg::frr_kind_e O_RESET_KIND
);
    import frr_pkg::*;
    wire logic take;
    wire logic ena;
    wire logic exe;
    wire logic sw_done;
    // accepted transfers, command bytes and a finished software reset
    assign take    = I_HSEL && I_HREADY && I_HTRANS == HTRANS_NONSEQ && I_HSIZE == HSIZE_WORD;
    assign ena     = I_CMD_VALID && I_CMD == CMD_RESET_ENABLE;
    assign exe     = I_CMD_VALID && I_CMD == CMD_RESET_EXECUTE;
    assign sw_done = O_RESET_PULSE && O_RESET_KIND == KIND_SW;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);
    // regs move at the event edge, so the pulse cycle is two edges on
    a_sw_keep_lock: assert property (sw_done |-> O_PPB_LOCK == $past(O_PPB_LOCK, 2))
        else $error("lock changed by software reset");
    a_sw_keep_dyb: assert property (sw_done |-> O_DYB_ACCESS == $past(O_DYB_ACCESS,2))
        else $error("dynamic access changed by software reset");
    a_por_kind: assert property (I_POR |=> O_RESET_KIND == KIND_POR)
        else $error("power-on not reported");
    a_hw_pulse: assert property (I_HW_RST |-> ##[1:2] O_RESET_PULSE)
        else $error("pin reset gave no pulse");
    a_sw_pair_fires: assert property (ena ##1 !I_CMD_VALID ##1 exe |-> ##[1:2] sw_done)
        else $error("command pair gave no software reset");
    a_sw_stray_cancels: assert property (ena ##2 (I_CMD_VALID && !ena && !exe) ##2 exe
        |-> ##1 !O_RESET_PULSE ##1 !O_RESET_PULSE) else $error("cancelled pair still reset");
    a_read_wait: assert property (take && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && I_HWRITE |=> O_HREADYOUT)
        else $error("write stalled");
    a_resp_okay: assert property (O_HRESP == 1'b0)
        else $error("bus response not okay");
    c_sw: cover property (sw_done);
    c_hw: cover property (I_HW_RST ##[1:2] O_RESET_PULSE);
    c_rd: cover property (take && !I_HWRITE ##2 O_HREADYOUT);
endmodule

bind frr_reload frr_reload_props frr_reload_props_i (
    .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_POR(I_POR), .I_HW_RST(I_HW_RST),
    .I_CMD_VALID(I_CMD_VALID), .I_CMD(I_CMD), .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS),
    .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HREADY(I_HREADY),
    .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_PPB_LOCK(O_PPB_LOCK),
    .O_DYB_ACCESS(O_DYB_ACCESS), .O_RESET_PULSE(O_RESET_PULSE), .O_RESET_KIND(O_RESET_KIND)
);

// [verif/frr_host_model.sv]
`timescale 1ns/1ps
// far-end host: command pair and chip-select signalling reset
module frr_host_model (
    input  wire logic       I_CLOCK,
    output logic            o_cs_b,
    output logic            o_dq0,
    output logic            o_cmd_valid,
    output logic      [7:0] o_cmd
);
    import frr_pkg::*;
    initial
    begin
        o_cs_b      = 1'b1;
        o_dq0       = 1'b1;
        o_cmd_valid = 1'b0;
        o_cmd       = 8'h00;
    end
    // one byte then a quiet cycle; idle byte is scrambled, not held
    task automatic send(input logic [7:0] c);
        @(posedge I_CLOCK);
        o_cmd_valid <= 1'b1;
        o_cmd       <= c;
        @(posedge I_CLOCK);
        o_cmd_valid <= 1'b0;
        o_cmd       <= ~c;
    endtask
    // enable directly before execute; a stray byte between cancels it
    task automatic sw_reset(input logic stray, input logic [7:0] junk);
        send(CMD_RESET_ENABLE);
        if (stray)
            send(junk);
        send(CMD_RESET_EXECUTE);
    endtask
    // four pulses, dq0 0,1,0,1 while selected; dq0 flips when released
    task automatic sig_reset();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge I_CLOCK);
            o_cs_b <= 1'b0;
            o_dq0  <= i[0];
            repeat (2) @(posedge I_CLOCK);
            o_cs_b <= 1'b1;
            o_dq0  <= ~i[0];
            @(posedge I_CLOCK);
        end
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
// reload bench: every reset kind over random options, reads checked by a monitor
module testbench;
    import frr_pkg::*;
    logic             clk;
    logic             rst_b;
    logic             por;
    logic             hw_rst;
    logic             hsel;
    logic      [31:0] haddr;
    logic      [1:0]  htrans;
    logic             hwrite;
    logic      [2:0]  hsize;
    logic      [31:0] hwdata;
    logic             cs_b;
    logic             dq0;
    logic             cmd_valid;
    logic      [7:0]  cmd;
    logic      [31:0] hrdata;
    logic             hready;
    logic             pulse;
    logic      [31:0] cfg;
    logic             rd_pend = 1'b0;
    logic      [31:0] rnd;
    logic      [31:0] nv;
    logic      [31:0] pwd;
    logic      [7:0]  opt;
    logic      [1:0]  vp;
    frr_kind_e        ek;
    int               bad_count;
    int               checks;
    logic      [31:0] exp_q[$];
    logic      [7:0]  adr_q[$];

    frr_reload frr_reload_i (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_POR(por), .I_HW_RST(hw_rst), .I_CS_B(cs_b),
        .I_DQ0(dq0), .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(),
        .O_CFG(cfg), .O_PPB_LOCK(), .O_DYB_ACCESS(), .O_RESET_PULSE(pulse), .O_RESET_KIND()
    );
    frr_host_model frr_host_model_i (
        .I_CLOCK(clk), .o_cs_b(cs_b), .o_dq0(dq0), .o_cmd_valid(cmd_valid), .o_cmd(cmd)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded wait for hready (sel 0) or the reset pulse (sel 1) at an edge
    task automatic wait_for(input logic sel, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while ((sel ? pulse : hready) !== 1'b1 && n < lim);
        // an answer on the last allowed edge still counts; a hang ends the run
        if ((sel ? pulse : hready) !== 1'b1)
        begin
            bad_count++;
            end_of_test();
        end
    endtask

    // single word transfer; a read leaves its expected word for the monitor
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_for(1'b0, 20);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : rnd;
        if (!wr)
        begin
            exp_q.push_back(d);
            adr_q.push_back(a);
        end
        wait_for(1'b0, 20);
    endtask

    // kinds: 0 power-on, 1 pin, 2 signalling, 3 command pair
    task automatic do_reset(input int k);
        if (k < 2)
        begin
            @(posedge clk);
            por    <= (k == 0);
            hw_rst <= (k == 1);
            @(posedge clk);
            por    <= 1'b0;
            hw_rst <= 1'b0;
        end
        else if (k == 2)
            frr_host_model_i.sig_reset();
        else
            frr_host_model_i.sw_reset(1'b0, 8'h00);
        wait_for(1'b1, 40);
        repeat (3) @(posedge clk);
    endtask

    // a read ends where hready comes back high after its wait state
    always @(posedge clk)
    begin
        if (rd_pend && hready)
        begin
            check($sformatf("reg %h", adr_q.pop_front()), hrdata, exp_q.pop_front());
            rd_pend <= 1'b0;
        end
        if (hsel && htrans == HTRANS_NONSEQ && !hwrite && hready)
            rd_pend <= 1'b1;
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        {rst_b, por, hw_rst, hsel, hwrite} = 5'h00;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = HSIZE_WORD;
        bad_count = 0;
        checks = 0;
        rnd = 32'h6779;
        pwd = 32'hffff_ffff;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // release acts as power-on with erased options
        bus(OFS_VPROT, 1'b0, 32'h1);
        bus(OFS_VPWD, 1'b0, pwd);
        bus(OFS_STATUS, 1'b0, {29'h0, KIND_POR, 1'b0});
        bus(8'h3c, 1'b1, rnd);
        bus(8'h3c, 1'b0, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            repeat (9) rnd = lfsr(rnd);
            nv  = rnd;
            opt = rnd[23:16];
            // nonvolatile side, then volatile copies that differ from it
            bus(OFS_NV_CFG, 1'b1, nv);
            bus(OFS_NV_PWD, 1'b1, ~nv);
            bus(OFS_NV_DLP, 1'b1, {24'h0, nv[15:8]});
            bus(OFS_NV_BOOT, 1'b1, nv ^ 32'h5a5a_5a5a);
            bus(OFS_PROT_OPT, 1'b1, {24'h0, opt});
            bus(OFS_VPROT, 1'b1, {30'h0, ~nv[1:0]});
            bus(OFS_VDLP, 1'b1, {24'h0, ~nv[15:8]});
            bus(OFS_VBOOT, 1'b1, ~nv);
            for (int j = 0; j < 4; j++)
                bus(OFS_ECC_STAT + 8'(4 * j), 1'b1, nv | 32'h1);
            do_reset(i % 4);
            // full reset reloads protection and boot side, software reset keeps them
            vp  = (i % 4 == 3) ? ~nv[1:0] : {opt[4], opt[2:1] != 2'b01};
            pwd = (i % 4 == 3) ? pwd : ((opt[2] && opt[0]) ? ~nv : 32'hffff_ffff);
            ek  = (i % 4 == 3) ? KIND_SW : ((i % 4 == 0) ? KIND_POR : KIND_HW);
            check("cfg port", cfg, nv);
            bus(OFS_VCFG, 1'b0, nv);
            bus(OFS_VPROT, 1'b0, {30'h0, vp});
            bus(OFS_VPWD, 1'b0, pwd);
            bus(OFS_VDLP, 1'b0, {24'h0, (i % 4 == 3) ? ~nv[15:8] : nv[15:8]});
            bus(OFS_VBOOT, 1'b0, (i % 4 == 3) ? ~nv : nv ^ 32'h5a5a_5a5a);
            for (int j = 0; j < 4; j++)
                bus(OFS_ECC_STAT + 8'(4 * j), 1'b0, 32'h0);
            bus(OFS_STATUS, 1'b0, {29'h0, ek, 1'b0});
        end
        // stray byte between enable and execute: no reload, disarmed
        bus(OFS_NV_CFG, 1'b1, ~nv);
        frr_host_model_i.sw_reset(1'b1, 8'h05);
        repeat (4) @(posedge clk);
        bus(OFS_VCFG, 1'b0, nv);
        bus(OFS_STATUS, 1'b0, {29'h0, KIND_SW, 1'b0});
        // bus traffic is not a command, so the enable stays armed
        frr_host_model_i.send(CMD_RESET_ENABLE);
        bus(OFS_STATUS, 1'b0, {29'h0, KIND_SW, 1'b1});
        frr_host_model_i.send(CMD_RESET_EXECUTE);
        repeat (4) @(posedge clk);
        bus(OFS_VCFG, 1'b0, ~nv);
        repeat (5) @(posedge clk);
        if (exp_q.size() != 0)
            bad_count++;
        end_of_test();
    end
endmodule
